/* include/sbtec_consts.svh */
`ifndef SBTEC_CONSTS_SVH
`define SBTEC_CONSTS_SVH

// ****************************************
// register offsets (word index on the plain port)
// ****************************************
`define SBTEC_ADDR_COUNT 4'h0
`define SBTEC_ADDR_CC_A 4'h1
`define SBTEC_ADDR_CC_B 4'h2
`define SBTEC_ADDR_MODE 4'h3
`define SBTEC_ADDR_OUT 4'h4
`define SBTEC_ADDR_PRE 4'h5
`define SBTEC_ADDR_CAP 4'h6

// ****************************************
// field positions
// ****************************************
`define SBTEC_MODE_HI 3
`define SBTEC_MODE_LO 2
`define SBTEC_MODE_INV_EDGE 1
`define SBTEC_OUT_ENABLE 0
`define SBTEC_OUT_TOGGLE 1
`define SBTEC_PRE_CLK_HI 1
`define SBTEC_PRE_CLK_LO 0
`define SBTEC_PRE_EDGE_A_HI 5
`define SBTEC_PRE_EDGE_A_LO 4
`define SBTEC_PRE_EDGE_B_HI 7
`define SBTEC_PRE_EDGE_B_LO 6
`define SBTEC_CAP_A_CAPTURE 0
`define SBTEC_CAP_A_REVERSE 1
`define SBTEC_CAP_B_CAPTURE 2

// ****************************************
// writable bit masks and reset values
// ****************************************
`define SBTEC_MODE_MASK 8'h0e
`define SBTEC_OUT_MASK 8'h03
`define SBTEC_PRE_MASK 8'hf3
`define SBTEC_CAP_MASK 8'h07
`define SBTEC_RST_WORD 16'h0000
`define SBTEC_RST_BYTE 8'h00

// ****************************************
// count clock selection and prescaler taps
// ****************************************
`define SBTEC_CLK_DIRECT 2'h0
`define SBTEC_CLK_DIV4 2'h1
`define SBTEC_CLK_DIV256 2'h2
`define SBTEC_CLK_EVENT 2'h3
`define SBTEC_DIV4_TAP 8'h03
`define SBTEC_DIV256_TAP 8'hff

// ****************************************
// valid edge select codes
// ****************************************
`define SBTEC_EDGE_FALL 2'h0
`define SBTEC_EDGE_RISE 2'h1
`define SBTEC_EDGE_BOTH 2'h3

`endif

/* include/sbtec_pkg.sv */
package sbtec_pkg;

  typedef enum logic [1:0] {
    sbtec_stopped,
    sbtec_free_run,
    sbtec_edge_clear,
    sbtec_match_clear
  } sbtec_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } sbtec_reg_req_t;

  typedef struct packed {
    logic [1:0] hist;
    logic stable;
    logic valid;
    logic reverse;
  } sbtec_edge_state_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] cc_a;
    logic [15:0] cc_b;
    logic [7:0] mode_ctl;
    logic [7:0] out_ctl;
    logic [7:0] pre_sel;
    logic [7:0] cap_ctl;
    logic [7:0] div;
    logic primed;
    logic level;
    logic irq_a;
    logic irq_b;
    logic [15:0] rdata;
  } sbtec_state_t;

endpackage

/* src/sbtec_edge_detect.sv */
`timescale 1ns/10ps
`include "sbtec_consts.svh"

module sbtec_edge_detect (
  input wire logic clk,            // system clock
  input wire logic sys_rst,        // async reset, active high
  input wire logic sample,         // pin level, synchronous to clk
  input wire logic [1:0] edge_sel, // valid edge select code
  output logic valid,              // one-cycle pulse on an accepted valid edge
  output logic reverse             // one-cycle pulse on the opposite edge
);

  sbtec_pkg::sbtec_edge_state_t q;
  sbtec_pkg::sbtec_edge_state_t next_q;

  // ****************************************
  // filter and edge classification
  // ****************************************
  always_comb begin
    next_q = q;
    next_q.valid = 1'b0;
    next_q.reverse = 1'b0;
    next_q.hist = {q.hist[0], sample};
    // a new level counts only once two samples in a row agree on it
    if (q.hist[1] == q.hist[0] && q.hist[0] != q.stable) begin
      next_q.stable = q.hist[0];
      case (edge_sel)
        `SBTEC_EDGE_FALL: begin
          next_q.valid = !q.hist[0];
          next_q.reverse = q.hist[0];
        end
        `SBTEC_EDGE_RISE: begin
          next_q.valid = q.hist[0];
          next_q.reverse = !q.hist[0];
        end
        `SBTEC_EDGE_BOTH: begin
          next_q.valid = 1'b1;
        end
        default: begin
          // forbidden code: no edge is ever accepted
          next_q.valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign valid = q.valid;
  assign reverse = q.reverse;

endmodule

/* src/sbtec_timer.sv */
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
`include "sbtec_consts.svh"

// Contract
// - mode 11: match A clears, irq A, toggles
// - interval is compare A plus one ticks
// - compare B raises irq B on equality unless capture B is set
// - output control 03H toggles on match A in modes 11 and 10, on match B in mode 10 only
// - mode 00 stops and clears the counter
// - count clock 11 counts event A edges
// - first match after M+2, later M+1
// - edge needs two equal consecutive samples
// - edge code 01 rising, 11 both
// - mode 10: event A edge restarts count
// - mode 10 compare matches raise irq A/B
// - capture A on event B or reverse A
// - capture B on event A, then clear
// - mode bit 1 adds toggle on A edge
// - counter read does not disturb counting

module sbtec_timer (
  input wire logic clk,                            // system clock, 10 MHz
  input wire logic sys_rst,                        // async reset, active high
  input wire sbtec_pkg::sbtec_reg_req_t reg_req,   // register address, data, strobes
  output logic [15:0] reg_rdata,                   // read data, cycle after read strobe
  input wire logic event_input_a,                  // clear / capture / event pin
  input wire logic event_input_b,                  // capture pin for register A
  output logic timer_output,                       // timer output pin level
  output logic match_irq_a,                        // one-cycle pulse, match or capture A
  output logic match_irq_b                         // one-cycle pulse, match or capture B
);

  // ****************************************
  // state
  // ****************************************
  sbtec_pkg::sbtec_state_t q;
  sbtec_pkg::sbtec_state_t next_q;

  logic [1:0] pin_level;
  logic [1:0] edge_sel [2];
  logic [1:0] edge_valid;
  logic [1:0] edge_reverse;

  assign pin_level = {event_input_b, event_input_a};
  assign edge_sel[0] = q.pre_sel[`SBTEC_PRE_EDGE_A_HI:`SBTEC_PRE_EDGE_A_LO];
  assign edge_sel[1] = q.pre_sel[`SBTEC_PRE_EDGE_B_HI:`SBTEC_PRE_EDGE_B_LO];

  // ****************************************
  // input edge detectors, index 0 is input a
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_edge
      sbtec_edge_detect u_edge (
        .clk(clk),
        .sys_rst(sys_rst),
        .sample(pin_level[gi]),
        .edge_sel(edge_sel[gi]),
        .valid(edge_valid[gi]),
        .reverse(edge_reverse[gi])
      );
    end
  endgenerate

  // ****************************************
  // decoded controls
  // ****************************************
  sbtec_pkg::sbtec_mode_t mode;
  logic running;
  logic [1:0] clk_sel;
  logic tick;
  logic out_enable;
  logic out_toggle;
  logic inv_on_edge;
  logic cap_a;
  logic cap_a_rev;
  logic cap_b;
  logic eq_a;
  logic eq_b;

  always_comb begin
    mode = sbtec_pkg::sbtec_mode_t'(q.mode_ctl[`SBTEC_MODE_HI:`SBTEC_MODE_LO]);
    running = (mode != sbtec_pkg::sbtec_stopped);
    clk_sel = q.pre_sel[`SBTEC_PRE_CLK_HI:`SBTEC_PRE_CLK_LO];
    out_enable = q.out_ctl[`SBTEC_OUT_ENABLE];
    out_toggle = q.out_ctl[`SBTEC_OUT_TOGGLE];
    inv_on_edge = q.mode_ctl[`SBTEC_MODE_INV_EDGE];
    cap_a = q.cap_ctl[`SBTEC_CAP_A_CAPTURE];
    cap_a_rev = q.cap_ctl[`SBTEC_CAP_A_REVERSE];
    cap_b = q.cap_ctl[`SBTEC_CAP_B_CAPTURE];
    eq_a = (q.count == q.cc_a);
    eq_b = (q.count == q.cc_b);
  end

  // ****************************************
  // count clock selection
  // ****************************************
  always_comb begin
    case (clk_sel)
      `SBTEC_CLK_DIRECT: begin
        tick = 1'b1;
      end
      `SBTEC_CLK_DIV4: begin
        tick = ((q.div & `SBTEC_DIV4_TAP) == `SBTEC_DIV4_TAP);
      end
      `SBTEC_CLK_DIV256: begin
        tick = (q.div == `SBTEC_DIV256_TAP);
      end
      `SBTEC_CLK_EVENT: begin
        tick = edge_valid[0];
      end
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_q = q;
    next_q.irq_a = 1'b0;
    next_q.irq_b = 1'b0;
    next_q.rdata = `SBTEC_RST_WORD;

    // software writes; hardware captures below take precedence
    if (reg_req.wr) begin
      case (reg_req.addr)
        `SBTEC_ADDR_CC_A: begin
          next_q.cc_a = reg_req.wdata;
        end
        `SBTEC_ADDR_CC_B: begin
          next_q.cc_b = reg_req.wdata;
        end
        `SBTEC_ADDR_MODE: begin
          next_q.mode_ctl = reg_req.wdata[7:0] & `SBTEC_MODE_MASK;
        end
        `SBTEC_ADDR_OUT: begin
          next_q.out_ctl = reg_req.wdata[7:0] & `SBTEC_OUT_MASK;
        end
        `SBTEC_ADDR_PRE: begin
          next_q.pre_sel = reg_req.wdata[7:0] & `SBTEC_PRE_MASK;
        end
        `SBTEC_ADDR_CAP: begin
          next_q.cap_ctl = reg_req.wdata[7:0] & `SBTEC_CAP_MASK;
        end
        default: begin
          // the counter and unmapped offsets ignore writes
          next_q.count = q.count;
        end
      endcase
    end

    if (!running) begin
      // stopped: counter held at zero, output idles low
      next_q.count = `SBTEC_RST_WORD;
      next_q.div = `SBTEC_RST_BYTE;
      next_q.primed = 1'b0;
      next_q.level = 1'b0;
    end else begin
      next_q.div = q.div + 8'h01;

      if (mode == sbtec_pkg::sbtec_edge_clear && edge_valid[0]) begin
        // the edge clear wins over any count tick in the same cycle
        next_q.count = `SBTEC_RST_WORD;
        next_q.primed = 1'b1;
        if (cap_b) begin
          next_q.cc_b = q.count;
          next_q.irq_b = 1'b1;
        end
        if (inv_on_edge) begin
          next_q.level = !next_q.level;
        end
      end else if (tick) begin
        if (!q.primed) begin
          // first tick after start only arms the counter, hence M+2 first time
          next_q.primed = 1'b1;
        end else begin
          if (mode == sbtec_pkg::sbtec_match_clear && eq_a) begin
            next_q.count = `SBTEC_RST_WORD;
          end else begin
            next_q.count = q.count + 16'h0001;
          end
          if (!cap_a && eq_a) begin
            next_q.irq_a = 1'b1;
            if (out_toggle && (mode == sbtec_pkg::sbtec_match_clear ||
                               mode == sbtec_pkg::sbtec_edge_clear)) begin
              next_q.level = !next_q.level;
            end
          end
          if (!cap_b && eq_b) begin
            next_q.irq_b = 1'b1;
            if (out_toggle && mode == sbtec_pkg::sbtec_edge_clear) begin
              next_q.level = !next_q.level;
            end
          end
        end
      end

      // capture into register a keeps the count running
      if (cap_a) begin
        if (edge_valid[1]) begin
          next_q.cc_a = q.count;
          next_q.irq_a = 1'b1;
        end else if (cap_a_rev && edge_reverse[0]) begin
          // reverse-phase capture deliberately raises no request
          next_q.cc_a = q.count;
        end
      end

      if (!out_enable) begin
        next_q.level = 1'b0;
      end
    end

    // reads only sample state, nothing is cleared by them
    if (reg_req.rd) begin
      case (reg_req.addr)
        `SBTEC_ADDR_COUNT: begin
          next_q.rdata = q.count;
        end
        `SBTEC_ADDR_CC_A: begin
          next_q.rdata = q.cc_a;
        end
        `SBTEC_ADDR_CC_B: begin
          next_q.rdata = q.cc_b;
        end
        `SBTEC_ADDR_MODE: begin
          next_q.rdata = {8'h00, q.mode_ctl};
        end
        `SBTEC_ADDR_OUT: begin
          next_q.rdata = {8'h00, q.out_ctl};
        end
        `SBTEC_ADDR_PRE: begin
          next_q.rdata = {8'h00, q.pre_sel};
        end
        `SBTEC_ADDR_CAP: begin
          next_q.rdata = {8'h00, q.cap_ctl};
        end
        default: begin
          next_q.rdata = `SBTEC_RST_WORD;
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = q.rdata;
  assign timer_output = q.level;
  assign match_irq_a = q.irq_a;
  assign match_irq_b = q.irq_b;

endmodule

/* test/sbtec_properties.sv */
`timescale 1ns/10ps
module sbtec_properties (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset
  input wire sbtec_pkg::sbtec_reg_req_t reg_req, // register port
  input wire logic [15:0] reg_rdata, // read data
  input wire logic event_input_a, // event pin a
  input wire logic event_input_b, // event pin b
  input wire logic timer_output, // output pin
  input wire logic match_irq_a, // irq a
  input wire logic match_irq_b // irq b
);
  logic [1:0] mode_sh;
  logic [1:0] clk_sh;
  logic out_en;
  logic cap_a;
  logic seen;
  logic [15:0] cc_sh;
  logic [15:0] gap;
  // ****************************************
  // control shadows snooped off the port
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_sh <= 2'h0;
      clk_sh <= 2'h0;
      out_en <= 1'b0;
      cap_a <= 1'b0;
      seen <= 1'b0;
      cc_sh <= 16'h0000;
      gap <= 16'h0000;
    end else begin
      if (reg_req.wr && reg_req.addr == 4'h3) mode_sh <= reg_req.wdata[3:2];
      if (reg_req.wr && reg_req.addr == 4'h5) clk_sh <= reg_req.wdata[1:0];
      if (reg_req.wr && reg_req.addr == 4'h4) out_en <= reg_req.wdata[0];
      if (reg_req.wr && reg_req.addr == 4'h6) cap_a <= reg_req.wdata[0];
      if (reg_req.wr && reg_req.addr == 4'h1) cc_sh <= reg_req.wdata;
      // any write breaks the steady interval, so the next gap is not judged
      seen <= !reg_req.wr && (seen || match_irq_a);
      gap <= match_irq_a ? 16'h0001 : gap + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_stopped;
    mode_sh == 2'h0 ##1 mode_sh == 2'h0;
  endsequence
  sequence s_rd(a);
    reg_req.rd && reg_req.addr == a;
  endsequence
  AST_RDATA_IDLE: assert property (!reg_req.rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  AST_STOP_QUIET: assert property (
      s_stopped |-> !match_irq_a && !match_irq_b && !timer_output)
    else $error("activity while stopped");
  AST_STOP_COUNT: assert property (s_stopped ##0 s_rd(4'h0) |=> reg_rdata == 16'h0000)
    else $error("count not zero while stopped");
  AST_IRQ_A_PULSE: assert property (match_irq_a |=> !match_irq_a)
    else $error("irq a longer than one cycle");
  AST_IRQ_B_PULSE: assert property (match_irq_b |=> !match_irq_b)
    else $error("irq b longer than one cycle");
  AST_INTERVAL: assert property (
      match_irq_a && seen && mode_sh == 2'h3 && clk_sh == 2'h0 |-> gap == cc_sh + 16'h0001)
    else $error("interval length wrong");
  AST_CCA_READ: assert property (s_rd(4'h1) ##0 !cap_a |=> reg_rdata == cc_sh)
    else $error("compare a readback wrong");
  AST_OUT_OFF: assert property (!out_en ##1 !out_en |-> !timer_output)
    else $error("output high while disabled");
endmodule

bind sbtec_timer sbtec_properties i_sbtec_properties (.clk(clk), .sys_rst(sys_rst),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .event_input_a(event_input_a),
  .event_input_b(event_input_b), .timer_output(timer_output), .match_irq_a(match_irq_a),
  .match_irq_b(match_irq_b));

/* test/sbtec_pins_model.sv */
`timescale 1ns/10ps
module sbtec_pins_model (
  input wire logic clk, // system clock
  output logic event_input_a, // event pin a
  output logic event_input_b // event pin b
);
  initial begin
    event_input_a = 1'b0;
    event_input_b = 1'b0;
  end
  // ****************************************
  // pins move just after a rising edge
  // ****************************************
  task automatic drive(input logic b, input logic lvl, input int hold);
    @(posedge clk);
    if (b) event_input_b <= lvl;
    else event_input_a <= lvl;
    repeat (hold) @(posedge clk);
  endtask
  // hold 0 gives a single-sample glitch, anything else a real pulse
  task automatic pulse(input logic b, input int hold);
    drive(b, 1'b1, hold);
    drive(b, 1'b0, hold);
  endtask
endmodule

/* test/sbtec_timer_tb.sv */
`timescale 1ns/10ps
module sbtec_timer_tb;
  logic clk;
  logic sys_rst;
  sbtec_pkg::sbtec_reg_req_t reg_req;
  logic [15:0] reg_rdata;
  logic event_input_a;
  logic event_input_b;
  logic timer_output;
  logic match_irq_a;
  logic match_irq_b;
  logic last_out = 1'b0;
  int err_total = 0;
  int checked = 0;
  int hits_a = 0;
  int hits_b = 0;
  int togs = 0;
  int a0;
  int b0;
  int t0;
  sbtec_timer i_sbtec_timer (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .event_input_a(event_input_a), .event_input_b(event_input_b),
    .timer_output(timer_output), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));
  sbtec_pins_model i_sbtec_pins_model (.clk(clk), .event_input_a(event_input_a),
    .event_input_b(event_input_b));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (match_irq_a === 1'b1) hits_a++;
    if (match_irq_b === 1'b1) hits_b++;
    if (timer_output !== last_out) togs++;
    last_out = timer_output;
  end
  // ****************************************
  // shared helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic snap();
    a0 = hits_a;
    b0 = hits_b;
    t0 = togs;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_a(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (match_irq_a !== 1'b1 && n < 2000);
  endtask
  task automatic pulse(input logic b, input int h);
    i_sbtec_pins_model.pulse(b, h);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [15:0] r;
    for (int i = 0; i < 8; i++) begin
      bus_rd(4'(i), r);
      check(r, 16'h0000);
    end
    $display("test reset done");
  endtask
  task automatic t_interval();
    int n;
    logic [15:0] r;
    bus_wr(4'h4, 16'h0003);
    bus_wr(4'h1, 16'h0003); // nonzero, set before start
    bus_wr(4'h2, 16'h0001);
    bus_wr(4'h3, 16'h000c);
    wait_a(n);
    wait_a(n);
    check(16'(n), 16'h0004);
    tick(1);
    snap();
    bus_rd(4'h0, r);
    check(16'(r <= 16'h0003), 16'h0001);
    wait_a(n);
    wait_a(n);
    check(16'(n), 16'h0004);
    tick(1);
    check(16'(hits_b - b0), 16'h0002);
    check(16'(togs - t0), 16'h0002);
    bus_wr(4'h3, 16'h0000);
    tick(2);
    bus_rd(4'h0, r);
    check(r, 16'h0000);
    $display("test interval done");
  endtask
  task automatic t_events();
    bus_wr(4'h5, 16'h0013); // event clock, rising edges
    bus_wr(4'h1, 16'h0002);
    bus_wr(4'h3, 16'h000c); // never mode 10 with the event clock
    snap();
    repeat (3) pulse(1'b0, 2);
    pulse(1'b0, 0);
    tick(4);
    check(16'(hits_a - a0), 16'h0000);
    pulse(1'b0, 2);
    tick(4);
    check(16'(hits_a - a0), 16'h0001);
    repeat (2) pulse(1'b0, 2);
    tick(4);
    check(16'(hits_a - a0), 16'h0001);
    pulse(1'b0, 2);
    tick(4);
    check(16'(hits_a - a0), 16'h0002);
    bus_wr(4'h3, 16'h0000);
    bus_wr(4'h5, 16'h0033);
    bus_wr(4'h3, 16'h000c);
    snap();
    for (int i = 0; i < 4; i++) i_sbtec_pins_model.drive(1'b0, !i[0], 2);
    tick(4);
    check(16'(hits_a - a0), 16'h0001);
    bus_wr(4'h3, 16'h0000);
    $display("test events done");
  endtask
  task automatic t_mode10();
    logic [15:0] r;
    bus_wr(4'h5, 16'h0010); // direct clock, never event a in mode 10
    bus_wr(4'h1, 16'h0005);
    bus_wr(4'h2, 16'h0009);
    for (int k = 0; k < 2; k++) begin
      bus_wr(4'h3, 16'h0000);
      bus_wr(4'h3, k ? 16'h000a : 16'h0008);
      tick(20);
      snap();
      pulse(1'b0, 2);
      tick(20);
      check(16'(hits_a - a0), 16'h0001);
      check(16'(hits_b - b0), 16'h0001);
      check(16'(togs - t0), 16'(2 + k));
    end
    bus_wr(4'h6, 16'h0004);
    tick(20);
    snap();
    pulse(1'b0, 2);
    bus_rd(4'h0, r);
    check(16'(r < 16'h0010), 16'h0001);
    bus_rd(4'h2, r);
    check(16'(r > 16'h0010), 16'h0001);
    check(16'(hits_b - b0), 16'h0001);
    bus_wr(4'h5, 16'h0050);
    bus_wr(4'h6, 16'h0001);
    tick(10);
    snap();
    pulse(1'b1, 2);
    tick(2);
    check(16'(hits_a - a0), 16'h0001);
    bus_rd(4'h1, r);
    check(16'(r > 16'h0005), 16'h0001);
    // reverse phase of input a: capture only, no request
    bus_wr(4'h6, 16'h0003);
    snap();
    pulse(1'b0, 2);
    tick(4);
    check(16'(hits_a - a0), 16'h0000);
    bus_rd(4'h1, r);
    check(r, 16'h0002);
    $display("test mode 10 done");
  endtask
  task automatic t_prescale();
    int n;
    logic [15:0] r;
    bus_wr(4'h3, 16'h0000);
    bus_wr(4'h6, 16'h0000);
    bus_wr(4'h1, 16'h0001);
    bus_wr(4'h2, 16'h0001);
    for (int p = 1; p < 3; p++) begin
      bus_wr(4'h5, 16'(p));
      bus_wr(4'h3, 16'h000c);
      wait_a(n);
      wait_a(n);
      check(16'(n), (p == 1) ? 16'h0008 : 16'h0200);
      bus_wr(4'h3, 16'h0000);
    end
    // free-running count still raises the compare b request
    bus_wr(4'h5, 16'h0000);
    bus_wr(4'h3, 16'h0004);
    snap();
    tick(12);
    check(16'(hits_b - b0), 16'h0001);
    bus_rd(4'h0, r);
    check(16'(r > 16'h0004), 16'h0001);
    bus_wr(4'h3, 16'h0000);
    $display("test prescale done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    err_total++;
    finish_test();
  end
  initial begin
    reg_req = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_interval();
    t_events();
    t_mode10();
    t_prescale();
    finish_test();
  end
endmodule
